// ===== rtl/adcrc_pkg.sv
// Package: constants, layouts and state types of the ADC result and compare registers
package adcrc_pkg;

  // Sizes
  localparam int unsigned NUM_RES = 12;
  localparam int unsigned RES_W   = 10;
  localparam int unsigned TGT_W   = 4;
  localparam int unsigned TGT_TOP = 3;
  localparam int unsigned CFG_W   = 6;
  localparam int unsigned IRQ_W   = 2;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned WORD_B  = 4;

  // Byte offsets on the APB
  localparam logic [11:0] OFS_RES0  = 12'h000;
  localparam logic [11:0] OFS_PRIO  = 12'h030;
  localparam logic [11:0] OFS_THR0  = 12'h034;
  localparam logic [11:0] OFS_THR1  = 12'h038;
  localparam logic [11:0] OFS_MCFG0 = 12'h03c;
  localparam logic [11:0] OFS_MCFG1 = 12'h040;
  localparam logic [11:0] OFS_ISTS  = 12'h044;
  localparam logic [11:0] OFS_IMSK  = 12'h048;

  // Field positions
  localparam int unsigned RES_LSB     = 6;
  localparam int unsigned RES_MSB     = 15;
  localparam int unsigned OVR_BIT     = 1;
  localparam int unsigned STORED_BIT  = 0;
  localparam int unsigned CFG_EN_BIT  = 0;
  localparam int unsigned CFG_TGT_LSB = 1;
  localparam int unsigned CFG_TGT_MSB = 4;
  localparam int unsigned CFG_DIR_BIT = 5;

  // Reset value of every register
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Whole state of the register slice
  typedef struct packed {
    logic [NUM_RES-1:0][RES_W-1:0] res;
    logic [NUM_RES-1:0]            stored;
    logic [NUM_RES-1:0]            ovr;
    logic [RES_W-1:0]              prio;
    logic                          prio_stored;
    logic                          prio_ovr;
    logic [RES_W-1:0]              thr0;
    logic [RES_W-1:0]              thr1;
    logic [CFG_W-1:0]              cfg0;
    logic [CFG_W-1:0]              cfg1;
    logic [IRQ_W-1:0]              irq_sts;
    logic [IRQ_W-1:0]              irq_msk;
    logic [31:0]                   rdata;
  } adcrc_state_t;

  // State of one monitor channel
  typedef struct packed {
    logic hit;
  } adcrc_mon_state_t;

  // Byte offset of normal result register i
  function automatic logic [11:0] res_ofs(input int unsigned i);
    res_ofs = OFS_RES0 + 12'(i * WORD_B);
  endfunction

  // Value placed in its field, all else zero
  function automatic logic [31:0] pack_value(input logic [RES_W-1:0] v);
    pack_value = REG_RESET;
    pack_value[RES_MSB:RES_LSB] = v;
  endfunction

  // Result word with its two flags
  function automatic logic [31:0] pack_result(input logic [RES_W-1:0] v,
                                              input logic ovr,
                                              input logic stored);
    pack_result = pack_value(v);
    pack_result[OVR_BIT] = ovr;
    pack_result[STORED_BIT] = stored;
  endfunction

endpackage

// ===== rtl/adcrc_monitor.sv
// One threshold monitor channel: target select, compare and hit pulse
`timescale 1ns/1ps
module adcrc_monitor (
  // Clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // Channel configuration
  input  wire logic                                enable,
  input  wire logic [adcrc_pkg::TGT_W-1:0]         target,
  input  wire logic                                direction,
  input  wire logic [adcrc_pkg::RES_W-1:0]         threshold,
  // Result stores from the converter
  input  wire logic [adcrc_pkg::NUM_RES-1:0]       res_store,
  input  wire logic [adcrc_pkg::RES_W-1:0]         res_value,
  input  wire logic                                prio_store,
  input  wire logic [adcrc_pkg::RES_W-1:0]         prio_value,
  // Registered one-cycle hit
  output logic                                     hit_pulse
);

  adcrc_pkg::adcrc_mon_state_t q;
  adcrc_pkg::adcrc_mon_state_t d;
  logic                        sel_store;
  logic [adcrc_pkg::RES_W-1:0] sel_value;

  // Direction 0 flags values below, 1 values above the threshold
  function automatic logic exceeds(input logic [adcrc_pkg::RES_W-1:0] v,
                                   input logic [adcrc_pkg::RES_W-1:0] thr,
                                   input logic dir);
    exceeds = dir ? (v > thr) : (v < thr);
  endfunction

  // Top code bit picks the priority register, else one of results 0 to 7
  always_comb begin
    if (target[adcrc_pkg::TGT_TOP]) begin
      sel_store = prio_store;
      sel_value = prio_value;
    end else begin
      sel_store = res_store[target[adcrc_pkg::TGT_TOP-1:0]];
      sel_value = res_value;
    end
    d.hit = enable & sel_store & exceeds(sel_value, threshold, direction);
  end

  // Registered hit: one pulse per qualifying store, never a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hit_pulse = q.hit;

  default clocking mcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SEL_PRIO: assert property (enable && target[adcrc_pkg::TGT_TOP] && prio_store
    && exceeds(prio_value, threshold, direction) |=> hit_pulse)
    else $error("Priority target store did not hit");
  AST_SEL_NORM: assert property (!target[adcrc_pkg::TGT_TOP]
    && !res_store[target[adcrc_pkg::TGT_TOP-1:0]] |=> !hit_pulse)
    else $error("Hit without a store to the selected register");
  AST_DIR_LOW: assert property (hit_pulse && !$past(direction)
    |-> $past(sel_value) < $past(threshold))
    else $error("Low direction hit on a value not below threshold");
  AST_DIR_HIGH: assert property (hit_pulse && $past(direction)
    |-> $past(sel_value) > $past(threshold))
    else $error("High direction hit on a value not above threshold");
  AST_EN_OFF: assert property (!enable |=> !hit_pulse)
    else $error("Disabled monitor produced a hit");

endmodule // adcrc_monitor

// ===== rtl/adcrc_regs.sv
// ADC result, overrun and threshold compare registers behind an APB slave
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module adcrc_regs (
  // Clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // APB slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [adcrc_pkg::ADDR_W-1:0]        paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // Normal result stores, one strobe per register
  input  wire logic [adcrc_pkg::NUM_RES-1:0]       res_store,
  input  wire logic [adcrc_pkg::RES_W-1:0]         res_value,
  // Priority result store
  input  wire logic                                prio_store,
  input  wire logic [adcrc_pkg::RES_W-1:0]         prio_value,
  // Interrupts
  output logic                                     monitor_irq_zero,
  output logic                                     monitor_irq_one,
  output logic                                     irq
);

  adcrc_pkg::adcrc_state_t       q;
  adcrc_pkg::adcrc_state_t       d;
  logic                          rd_setup;
  logic                          wr_acc;
  logic [adcrc_pkg::NUM_RES-1:0] res_rd;
  logic                          prio_rd;
  logic                          sts_rd;
  logic                          mapped;
  logic [31:0]                   rd_mux;
  logic [adcrc_pkg::IRQ_W-1:0]   mon_pulse;

  // Address match, used by every decode below
  function automatic logic is_addr(input logic [adcrc_pkg::ADDR_W-1:0] a,
                                   input logic [adcrc_pkg::ADDR_W-1:0] ofs);
    is_addr = (a == ofs);
  endfunction

  // Reads are sampled in the setup cycle, writes land in the access cycle
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_acc   = psel & penable & pwrite;

  // Read strobes that clear flags; the captured word and the clear share an edge
  always_comb begin
    for (int unsigned i = 0; i < adcrc_pkg::NUM_RES; i++) begin
      res_rd[i] = rd_setup & is_addr(paddr, adcrc_pkg::res_ofs(i));
    end
    prio_rd = rd_setup & is_addr(paddr, adcrc_pkg::OFS_PRIO);
    sts_rd  = rd_setup & is_addr(paddr, adcrc_pkg::OFS_ISTS);
  end

  // Read data mux; reserved bits stay zero
  always_comb begin
    rd_mux = adcrc_pkg::REG_RESET;
    mapped = 1'b0;
    for (int unsigned i = 0; i < adcrc_pkg::NUM_RES; i++) begin
      if (is_addr(paddr, adcrc_pkg::res_ofs(i))) begin
        rd_mux = adcrc_pkg::pack_result(q.res[i], q.ovr[i], q.stored[i]);
        mapped = 1'b1;
      end
    end
    if (is_addr(paddr, adcrc_pkg::OFS_PRIO)) begin
      rd_mux = adcrc_pkg::pack_result(q.prio, q.prio_ovr, q.prio_stored);
      mapped = 1'b1;
    end
    if (is_addr(paddr, adcrc_pkg::OFS_THR0)) begin
      rd_mux = adcrc_pkg::pack_value(q.thr0);
      mapped = 1'b1;
    end
    if (is_addr(paddr, adcrc_pkg::OFS_THR1)) begin
      rd_mux = adcrc_pkg::pack_value(q.thr1);
      mapped = 1'b1;
    end
    if (is_addr(paddr, adcrc_pkg::OFS_MCFG0)) begin
      rd_mux = 32'(q.cfg0);
      mapped = 1'b1;
    end
    if (is_addr(paddr, adcrc_pkg::OFS_MCFG1)) begin
      rd_mux = 32'(q.cfg1);
      mapped = 1'b1;
    end
    if (is_addr(paddr, adcrc_pkg::OFS_ISTS)) begin
      rd_mux = 32'(q.irq_sts);
      mapped = 1'b1;
    end
    if (is_addr(paddr, adcrc_pkg::OFS_IMSK)) begin
      rd_mux = 32'(q.irq_msk);
      mapped = 1'b1;
    end
  end

  // Next state: stores, flags, software writes and sticky status
  always_comb begin
    d = q;
    // A store in the same cycle as the clearing read keeps its flags
    for (int unsigned i = 0; i < adcrc_pkg::NUM_RES; i++) begin
      if (res_store[i]) begin
        d.res[i] = res_value;
      end
      d.stored[i] = res_store[i] | (q.stored[i] & ~res_rd[i]);
      d.ovr[i]    = (res_store[i] & q.stored[i]) | (q.ovr[i] & ~res_rd[i]);
    end
    if (prio_store) begin
      d.prio = prio_value;
    end
    d.prio_stored = prio_store | (q.prio_stored & ~prio_rd);
    d.prio_ovr    = (prio_store & q.prio_stored) | (q.prio_ovr & ~prio_rd);
    // Thresholds are taken even while a monitor runs; software must avoid that
    if (wr_acc && is_addr(paddr, adcrc_pkg::OFS_THR0)) begin
      d.thr0 = pwdata[adcrc_pkg::RES_MSB:adcrc_pkg::RES_LSB];
    end
    if (wr_acc && is_addr(paddr, adcrc_pkg::OFS_THR1)) begin
      d.thr1 = pwdata[adcrc_pkg::RES_MSB:adcrc_pkg::RES_LSB];
    end
    if (wr_acc && is_addr(paddr, adcrc_pkg::OFS_MCFG0)) begin
      d.cfg0 = pwdata[adcrc_pkg::CFG_W-1:0];
    end
    if (wr_acc && is_addr(paddr, adcrc_pkg::OFS_MCFG1)) begin
      d.cfg1 = pwdata[adcrc_pkg::CFG_W-1:0];
    end
    if (wr_acc && is_addr(paddr, adcrc_pkg::OFS_IMSK)) begin
      d.irq_msk = pwdata[adcrc_pkg::IRQ_W-1:0];
    end
    // Monitor hits are sticky; a hit beats the clearing read
    d.irq_sts = mon_pulse | (q.irq_sts & ~{adcrc_pkg::IRQ_W{sts_rd}});
    // Read word is frozen in the setup cycle and held through access
    if (rd_setup) begin
      d.rdata = rd_mux;
    end
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Monitor channel zero
  adcrc_monitor u_mon_zero (
    .pclk       (pclk),
    .presetn    (presetn),
    .enable     (q.cfg0[adcrc_pkg::CFG_EN_BIT]),
    .target     (q.cfg0[adcrc_pkg::CFG_TGT_MSB:adcrc_pkg::CFG_TGT_LSB]),
    .direction  (q.cfg0[adcrc_pkg::CFG_DIR_BIT]),
    .threshold  (q.thr0),
    .res_store  (res_store),
    .res_value  (res_value),
    .prio_store (prio_store),
    .prio_value (prio_value),
    .hit_pulse  (mon_pulse[0])
  );

  // Monitor channel one
  adcrc_monitor u_mon_one (
    .pclk       (pclk),
    .presetn    (presetn),
    .enable     (q.cfg1[adcrc_pkg::CFG_EN_BIT]),
    .target     (q.cfg1[adcrc_pkg::CFG_TGT_MSB:adcrc_pkg::CFG_TGT_LSB]),
    .direction  (q.cfg1[adcrc_pkg::CFG_DIR_BIT]),
    .threshold  (q.thr1),
    .res_store  (res_store),
    .res_value  (res_value),
    .prio_store (prio_store),
    .prio_value (prio_value),
    .hit_pulse  (mon_pulse[1])
  );

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = q.rdata;

  // Interrupt outputs
  assign monitor_irq_zero = mon_pulse[0];
  assign monitor_irq_one  = mon_pulse[1];
  assign irq              = |(q.irq_sts & q.irq_msk);

  default clocking rcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RES_FIELD: assert property (rd_setup && is_addr(paddr, adcrc_pkg::OFS_RES0)
    |=> prdata[15:6] == $past(q.res[0]) && prdata[31:16] == 16'h0000
        && prdata[5:2] == 4'h0)
    else $error("Normal result read word malformed");
  // Read word and store path checked apart, so any gap between them is covered
  AST_PRIO_FIELD: assert property (rd_setup && is_addr(paddr, adcrc_pkg::OFS_PRIO)
    |=> prdata[15:6] == $past(q.prio) && prdata[31:16] == 16'h0000
        && prdata[5:2] == 4'h0)
    else $error("Priority read does not show the stored value");
  AST_PRIO_STORE: assert property (prio_store |=> q.prio == $past(prio_value))
    else $error("Priority store did not update the result");
  AST_OVR_SET: assert property (res_store[0] && q.stored[0]
    |=> q.ovr[0] && q.stored[0])
    else $error("Overwrite of unread result did not set overrun");
  AST_OVR_CLR: assert property (res_rd[0] && !res_store[0] |=> !q.ovr[0])
    else $error("Overrun not cleared by read");
  AST_PRIO_OVR: assert property (prio_store && q.prio_stored
    |=> q.prio_ovr && q.prio_stored)
    else $error("Priority overrun not set on overwrite");
  AST_PRIO_CLR: assert property (prio_rd && !prio_store
    |=> !q.prio_ovr && !q.prio_stored)
    else $error("Priority flags not cleared by read");
  // Stored flag holds until a read; a store always wins over the read
  AST_STORED: assert property (res_store[3] || (q.stored[3] && !res_rd[3])
    |=> q.stored[3])
    else $error("Stored flag lost without a read");
  AST_STORED_CLR: assert property (res_rd[3] && !res_store[3] |=> !q.stored[3])
    else $error("Stored flag not cleared by read");
  // Write access, one idle cycle, then the read setup of the same register
  AST_THR0: assert property (wr_acc && is_addr(paddr, adcrc_pkg::OFS_THR0)
    ##2 (rd_setup && is_addr(paddr, adcrc_pkg::OFS_THR0))
    |=> prdata[15:6] == $past(pwdata[15:6], 3) && prdata[5:0] == 6'h00
        && prdata[31:16] == 16'h0000)
    else $error("Threshold zero readback wrong");
  AST_THR1: assert property (wr_acc && is_addr(paddr, adcrc_pkg::OFS_THR1)
    |=> q.thr1 == $past(pwdata[15:6]))
    else $error("Threshold one not written");
  AST_MON_STS: assert property (monitor_irq_zero
    |=> q.irq_sts[0] && (!q.irq_msk[0] || irq))
    else $error("Monitor hit did not reach status and interrupt");

  COV_OVERRUN: cover property (res_store[0] && q.stored[0]);
  COV_MON_ZERO: cover property (monitor_irq_zero);
  COV_PRIO_READ: cover property (prio_rd && q.prio_stored);
  COV_UNMAPPED: cover property (pslverr);

endmodule // adcrc_regs

// ===== sim/adcrc_regs_test.sv
// Self-checking bench for the ADC result and threshold compare register slice
`timescale 1ns/1ps
module adcrc_regs_test;
  // Design inputs and outputs
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [11:0] res_store = 12'h000;
  logic [9:0]  res_value = 10'h000;
  logic        prio_store = 1'b0;
  logic [9:0]  prio_value = 10'h000;
  logic [31:0] prdata;
  logic        pready, pslverr, monitor_irq_zero, monitor_irq_one, irq;
  // Bench state and reference model
  int          errors = 0;
  int          compares = 0;
  int          mres[13], mst[13], mov[13], en[2], tg[2], dr[2], th[2];
  int          ists = 0;
  int          msk = 0;
  logic        slv;
  logic [31:0] r;

  adcrc_regs u_adcrc_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .res_store(res_store), .res_value(res_value), .prio_store(prio_store),
    .prio_value(prio_value), .monitor_irq_zero(monitor_irq_zero),
    .monitor_irq_one(monitor_irq_one), .irq(irq));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // Verdict, reached from the main sequence and the watchdog
  task automatic end_of_test;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk(32'h0, 32'h1, "no pready");
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Expected result word; reading it clears both flags in the model
  task automatic rd_res(input int i);
    apb(1'b0, 12'(i * 4), 32'h0);
    chk(r, (32'(mres[i]) << 6) | (32'(mov[i]) << 1) | 32'(mst[i]), "result");
    chk({31'h0, slv}, 32'h0, "slverr on result");
    mst[i] = 0;
    mov[i] = 0;
  endtask

  // One converter store (index 12 is the priority result), then watch both monitors
  task automatic st(input int i, input int v);
    int h[2], c[2], sel;
    for (int m = 0; m < 2; m++) begin
      sel = (tg[m] >= 8) ? 12 : tg[m];
      h[m] = int'(en[m] == 1 && i == sel && (dr[m] == 1 ? v > th[m] : v < th[m]));
      c[m] = 0;
    end
    // Each input is driven once per step; the idle value bus carries noise
    if (i < 12) begin
      res_store <= 12'h001 << i;
      res_value <= 10'(v);
      prio_value <= 10'($urandom);
    end else begin
      prio_store <= 1'b1;
      prio_value <= 10'(v);
      res_value <= 10'($urandom);
    end
    @(posedge pclk);
    res_store <= 12'h000;
    prio_store <= 1'b0;
    mov[i] = mov[i] | mst[i];
    mst[i] = 1;
    mres[i] = v;
    for (int k = 0; k < 3; k++) begin
      if (k > 0) @(posedge pclk);
      #1;
      c[0] += int'(monitor_irq_zero === 1'b1);
      c[1] += int'(monitor_irq_one === 1'b1);
    end
    @(posedge pclk);
    chk(32'(c[0]), 32'(h[0]), "monitor zero pulses");
    chk(32'(c[1]), 32'(h[1]), "monitor one pulses");
    ists = ists | h[0] | (h[1] << 1);
    chk({31'h0, irq}, 32'((ists & msk) != 0), "irq level");
  endtask

  // Watchdog sized well above the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_of_test();
  end

  initial begin
    int m, t, v, i;
    void'($urandom(32'he01b2ad4));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values of results and thresholds
    for (int k = 0; k < 15; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      chk(r, 32'h0, "reset value");
    end
    // Unmapped address answers with an error and zero data
    apb(1'b0, 12'h04c, 32'h0);
    chk(r, 32'h0, "unmapped data");
    chk({31'h0, slv}, 32'h1, "unmapped slverr");
    // Thresholds keep only their 10-bit field
    for (int k = 0; k < 2; k++) begin
      v = int'($urandom);
      apb(1'b1, 12'h034 + 12'(k * 4), 32'(v));
      apb(1'b0, 12'h034 + 12'(k * 4), 32'h0);
      chk(r, 32'(v) & 32'h0000_ffc0, "threshold readback");
    end
    // Every result: single store, double store for overrun, second read clears
    for (int k = 0; k < 13; k++) begin
      st(k, (k == 0) ? 1023 : int'($urandom % 1024));
      rd_res(k);
      st(k, int'($urandom % 1024));
      st(k, int'($urandom % 1024));
      apb(1'b1, 12'(k * 4), 32'hffff_ffff);
      rd_res(k);
      rd_res(k);
    end
    // Monitors over every target code group and both directions
    for (int k = 0; k < 40; k++) begin
      m = k % 2;
      t = (k / 2) % 10;
      if (t >= 8) t = (t == 8) ? 8 : 15;
      en[m] = 0;
      apb(1'b1, 12'h03c + 12'(m * 4), 32'h0);
      th[m] = int'($urandom % 1024);
      apb(1'b1, 12'h034 + 12'(m * 4), 32'(th[m] << 6));
      tg[m] = t;
      dr[m] = (k / 20) ^ int'($urandom % 2);
      en[m] = 1;
      apb(1'b1, 12'h03c + 12'(m * 4), 32'((dr[m] << 5) | (t << 1) | 1));
      apb(1'b0, 12'h03c + 12'(m * 4), 32'h0);
      chk(r, 32'((dr[m] << 5) | (t << 1) | 1), "monitor config");
      msk = int'($urandom % 4);
      apb(1'b1, 12'h048, 32'(msk));
      apb(1'b0, 12'h048, 32'h0);
      chk(r, 32'(msk), "irq mask");
      i = ($urandom % 4 == 0) ? int'($urandom % 13) : ((t >= 8) ? 12 : t);
      v = (k % 7 == 3) ? th[m] : int'($urandom % 1024);
      st(i, v);
      apb(1'b0, 12'h044, 32'h0);
      chk(r, 32'(ists), "irq status");
      ists = 0;
      chk({31'h0, irq}, 32'h0, "irq after status read");
    end
    // Flags left by the monitor stores
    for (int k = 0; k < 13; k++) rd_res(k);
    end_of_test();
  end
endmodule // adcrc_regs_test
